// >>> hw/supervisor_reset_watchdog.v
// How it works
// R1 - A low level on the manual-reset input starts a reset pulse.
// R2 - The manual-reset input is filtered so bounce yields one clean request.
// R3 - A triggered reset holds the active-low reset output low for 200 ms.
// R4 - Reset stays asserted for as long as supply-low is active.
// R5 - Reset is stretched 200 ms after supply-low clears and after manual reset releases.
// R6 - A watchdog expiry never asserts reset by itself; only wiring it to manual reset does.
// R7 - The watchdog output goes low when the kick input has no edge for 1.6 s.
// R8 - After expiry the watchdog output stays low until the timer is cleared.
// R9 - A floating or tri-stated kick input disables the watchdog.
// R10 - The timer clears on reset, on a tri-stated kick input and on every kick edge.
// R11 - The watchdog output is low whenever supply-low is active.
// R12 - When supply-low clears the watchdog output low-line hold ends at once.
// R13 - In the both build the active-high reset output is the complement of the active-low one.
// R14 - The power-fail flag is low while the sense input is below threshold, high otherwise.
// R15 - A build option picks low, high or both reset outputs; both drops the watchdog.
// R16 - Analog indications are synchronised and durations are cycle-count parameters.
`include "supervisor_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_watchdog #(
	parameter [1:0] VARIANT = `SUP_VARIANT_LOW,
	parameter integer RESET_CYCLES = `SUP_RESET_CYCLES,
	parameter integer WDOG_CYCLES = `SUP_WDOG_CYCLES,
	parameter integer DEBOUNCE_CYCLES = `SUP_DEBOUNCE_CYCLES,
	parameter integer CW = 32
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire supply_low,
	input wire manual_reset_req_n,
	input wire power_fail_below_in,
	input wire watchdog_kick_in,
	input wire watchdog_kick_hiz,
	output reg reset_out_n,
	output reg reset_out,
	output reg power_fail_flag_n,
	output reg watchdog_expired_n
);
	localparam HAS_LOW = (VARIANT != `SUP_VARIANT_HIGH);
	localparam HAS_HIGH = (VARIANT != `SUP_VARIANT_LOW);
	localparam HAS_WDOG = (VARIANT != `SUP_VARIANT_BOTH);

	// Reset pulse states, one-hot
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_HOLD = 3'h2;
	localparam [2:0] ST_STRETCH = 3'h4;

	wire mr_clean_n;
	wire mr_sync_unused;
	reg low_m, low_s;
	reg pf_m, pf_s;
	reg kick_m, kick_s, kick_prev;
	reg hiz_m, hiz_s;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [CW-1:0] hold_count;
	reg [CW-1:0] next_hold_count;
	reg [CW-1:0] wdog_count;
	reg wdog_fired;
	wire reset_active;
	wire kick_edge;

	// Manual reset is synchronised and debounced in one place [R2]
	sync_debounce #(
		.STABLE_CYCLES(DEBOUNCE_CYCLES),
		.CW(CW),
		.RESET_VALUE(1'b1)
	) u_mr_filter (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.raw_in(manual_reset_req_n),
		.clean_out(mr_clean_n),
		.sync_out(mr_sync_unused)
	);

	// Two-flop synchronisers for the comparator and kick pins [R16]
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			// Preset to the idle level so no false low-line pulse follows reset
			low_m <= 1'b0;
			low_s <= 1'b0;
			pf_m <= 1'b0;
			pf_s <= 1'b0;
			kick_m <= 1'b0;
			kick_s <= 1'b0;
			kick_prev <= 1'b0;
			hiz_m <= 1'b1;
			hiz_s <= 1'b1;
		end
		else
		begin
			low_m <= supply_low;
			low_s <= low_m;
			pf_m <= power_fail_below_in;
			pf_s <= pf_m;
			kick_m <= watchdog_kick_in;
			kick_s <= kick_m;
			kick_prev <= kick_s;
			hiz_m <= watchdog_kick_hiz;
			hiz_s <= hiz_m;
		end
	end

	// Either supply-low or a held manual reset keeps the pulse in HOLD
	assign reset_active = low_s | ~mr_clean_n; // [R1] [R4]

	// Pulse sequencer: HOLD while a cause stands, then STRETCH for the full width.
	// A new cause during STRETCH returns to HOLD so the 200 ms restarts from release.
	always @*
	begin
		next_state = state;
		next_hold_count = hold_count;
		case (state)
			ST_IDLE:
			begin
				if (reset_active)
					next_state = ST_HOLD; // [R1]
			end
			ST_HOLD:
			begin
				next_hold_count = {CW{1'b0}};
				if (!reset_active)
					next_state = ST_STRETCH; // [R5]
			end
			ST_STRETCH:
			begin
				if (reset_active)
				begin
					next_state = ST_HOLD; // [R4]
					next_hold_count = {CW{1'b0}};
				end
				else if (hold_count >= RESET_CYCLES[CW-1:0] - 1'b1)
				begin
					next_state = ST_IDLE; // [R3] [R5]
					next_hold_count = {CW{1'b0}};
				end
				else
					next_hold_count = hold_count + 1'b1;
			end
			default:
			begin
				next_state = ST_HOLD;
				next_hold_count = {CW{1'b0}};
			end
		endcase
	end

	// System reset comes up in HOLD so the processor sees a full pulse at power-up
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state <= ST_HOLD;
			hold_count <= {CW{1'b0}};
		end
		else
		begin
			state <= next_state;
			hold_count <= next_hold_count;
		end
	end

	// Reset outputs; an absent polarity rests at its inactive level.
	// The watchdog never feeds this path, only the external pin wiring does. [R6]
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			reset_out_n <= HAS_LOW ? 1'b0 : 1'b1;
			reset_out <= HAS_HIGH ? 1'b1 : 1'b0;
		end
		else
		begin
			reset_out_n <= HAS_LOW ? (next_state == ST_IDLE) : 1'b1; // [R15]
			reset_out <= HAS_HIGH ? (next_state != ST_IDLE) : 1'b0; // [R13] [R15]
		end
	end

	// Power-fail flag just follows the synchronised comparator
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			power_fail_flag_n <= 1'b1;
		else
			power_fail_flag_n <= ~pf_s; // [R14]
	end

	assign kick_edge = kick_s ^ kick_prev;

	// Watchdog timer; cleared by reset, tri-state or any kick edge
	always @(posedge sys_clk)
	begin
		if (sys_rst || !HAS_WDOG)
		begin
			wdog_count <= {CW{1'b0}};
			wdog_fired <= 1'b0;
		end
		else if ((state != ST_IDLE) || hiz_s || kick_edge)
		begin
			wdog_count <= {CW{1'b0}}; // [R9] [R10]
			wdog_fired <= 1'b0;
		end
		else if (wdog_count >= WDOG_CYCLES[CW-1:0] - 1'b1)
			wdog_fired <= 1'b1; // [R7] [R8]
		else
			wdog_count <= wdog_count + 1'b1;
	end

	// Low-line forces the watchdog output low with no stretch of its own
	always @(posedge sys_clk)
	begin
		if (sys_rst)
			watchdog_expired_n <= 1'b1;
		else if (!HAS_WDOG)
			watchdog_expired_n <= 1'b1; // [R15]
		else
			watchdog_expired_n <= ~(low_s | wdog_fired); // [R11] [R12]
	end
endmodule // supervisor_reset_watchdog
`default_nettype wire

// >>> hw/supervisor_regs.vh
`ifndef SUPERVISOR_REGS_VH
`define SUPERVISOR_REGS_VH
// Clock rate and documented durations
`define SUP_CLK_HZ 200000000
`define SUP_RESET_MS 200
`define SUP_WDOG_MS 1600
// Cycle counts derived from the rate (exact multiples, no rounding needed)
`define SUP_RESET_CYCLES (`SUP_CLK_HZ / 1000 * `SUP_RESET_MS)
`define SUP_WDOG_CYCLES (`SUP_CLK_HZ / 1000 * `SUP_WDOG_MS)
// Manual-reset debounce time in microseconds and cycles
`define SUP_DEBOUNCE_US 1000
`define SUP_DEBOUNCE_CYCLES (`SUP_CLK_HZ / 1000000 * `SUP_DEBOUNCE_US)
// Build variants of the reset outputs
`define SUP_VARIANT_LOW 2'h0
`define SUP_VARIANT_HIGH 2'h1
`define SUP_VARIANT_BOTH 2'h2
`endif

// >>> hw/sync_debounce.v
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser followed by a stability filter
module sync_debounce #(
	parameter integer STABLE_CYCLES = 16,
	parameter integer CW = 32,
	parameter RESET_VALUE = 1'b1
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire raw_in,
	output reg clean_out,
	output wire sync_out
);
	reg meta;
	reg sync;
	reg [CW-1:0] stable_count;

	// First flop feeds only the second one
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			meta <= RESET_VALUE;
			sync <= RESET_VALUE;
		end
		else
		begin
			meta <= raw_in;
			sync <= meta;
		end
	end

	assign sync_out = sync;

	// A level must hold for STABLE_CYCLES before it is accepted; bounce restarts the count
	always @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			clean_out <= RESET_VALUE;
			stable_count <= {CW{1'b0}};
		end
		else if (sync == clean_out)
			stable_count <= {CW{1'b0}};
		else if (stable_count >= STABLE_CYCLES[CW-1:0] - 1'b1)
		begin
			clean_out <= sync;
			stable_count <= {CW{1'b0}};
		end
		else
			stable_count <= stable_count + 1'b1;
	end
endmodule // sync_debounce
`default_nettype wire

// >>> bench/sup_kicker.sv
`timescale 1ns/1ps
`default_nettype none
// Processor side of the kick line
module sup_kicker #(
	parameter integer PERIOD = 10
) (
	input wire sys_clk,
	input wire alive,
	input wire float_pin,
	output logic kick
);
	int n = 0;
	initial kick = 1'b0;
	// Kicks come well inside the time-out; a floated pin is not driven, so it
	// shows no edges and only the float sense can stop the watchdog
	always @(negedge sys_clk)
	begin
		n <= (n >= PERIOD) ? 0 : n + 1;
		if (!float_pin && alive && n == PERIOD)
			kick <= ~kick;
	end
endmodule // sup_kicker
`default_nettype wire

// >>> bench/sup_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sup_monitor #(
	parameter integer RESET_CYCLES = 20,
	parameter integer WDOG_CYCLES = 50,
	parameter [1:0] VARIANT = 2'h0
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire supply_low,
	input wire manual_reset_req_n,
	input wire power_fail_below_in,
	input wire watchdog_kick_in,
	input wire watchdog_kick_hiz,
	input wire reset_out_n,
	input wire reset_out,
	input wire power_fail_flag_n,
	input wire watchdog_expired_n
);
	int lo = 0;
	int wd = 0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Quiet-cycle counters; wd saturates so a long idle never wraps
	always @(posedge sys_clk)
	begin
		if (sys_rst || reset_out_n || supply_low || !manual_reset_req_n)
			lo <= 0;
		else
			lo <= lo + 1;
		if (sys_rst || !reset_out_n || supply_low || watchdog_kick_hiz
			|| $changed(watchdog_kick_in))
			wd <= 0;
		else if (wd < WDOG_CYCLES + 9)
			wd <= wd + 1;
	end
	chk_pf_follow: assert property ($changed(power_fail_below_in) |-> ##3
		power_fail_flag_n == !$past(power_fail_below_in, 3)) else $error("flag lag");
	chk_low_reset: assert property (supply_low [*3] |=> !reset_out_n)
		else $error("reset not held");
	chk_low_wdog: assert property ((VARIANT != 2'h2 && supply_low) [*3]
		|=> !watchdog_expired_n) else $error("wdog not low");
	chk_high_inverse: assert property ((VARIANT == 2'h0) ? !reset_out :
		((VARIANT == 2'h1) ? reset_out_n : (reset_out == !reset_out_n)))
		else $error("high reset not inverse");
	chk_wdog_quick: assert property (supply_low [*4] ##1 !supply_low [*3]
		|=> watchdog_expired_n) else $error("wdog slow");
	chk_stretch_len: assert property ($rose(reset_out_n) |->
		$past(lo) >= RESET_CYCLES && $past(lo) <= RESET_CYCLES + 12) else $error("stretch");
	chk_manual_trig: assert property (!manual_reset_req_n [*8] |=> !reset_out_n)
		else $error("manual ignored");
	chk_no_spurious: assert property ((!supply_low && manual_reset_req_n
		&& reset_out_n) [*8] |=> reset_out_n) else $error("spurious reset");
	chk_wdog_fire: assert property (VARIANT != 2'h2 && wd >= WDOG_CYCLES + 8
		|-> !watchdog_expired_n) else $error("no expiry");
	chk_hiz_off: assert property ((watchdog_kick_hiz && !supply_low) [*4]
		|=> watchdog_expired_n) else $error("hiz ignored");
	cover property ($rose(reset_out_n));
	cover property ($fell(watchdog_expired_n) && !supply_low);
	cover property (!manual_reset_req_n [*8]);
endmodule // sup_monitor
bind supervisor_reset_watchdog sup_monitor #(.RESET_CYCLES(RESET_CYCLES),
	.WDOG_CYCLES(WDOG_CYCLES), .VARIANT(VARIANT)) u_mon (.sys_clk, .sys_rst,
	.supply_low, .manual_reset_req_n, .power_fail_below_in, .watchdog_kick_in,
	.watchdog_kick_hiz, .reset_out_n, .reset_out, .power_fail_flag_n,
	.watchdog_expired_n);
`default_nettype wire

// >>> bench/supervisor_reset_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_watchdog_tb;
	localparam int RC = 20;
	localparam int WC = 50;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic supply_low = 1'b0;
	logic mr_n = 1'b1;
	logic pf = 1'b0;
	logic alive = 1'b1;
	logic hiz = 1'b0;
	wire kick, rst_n, pf_n, wdo_n;
	wire rst_hi, rst_n_b, rst_hi_b, wdo_b;
	int bad_count = 0;
	int checks = 0;
	int n;
	// Small counts keep the run short
	supervisor_reset_watchdog #(.RESET_CYCLES(RC), .WDOG_CYCLES(WC),
		.DEBOUNCE_CYCLES(4)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.supply_low(supply_low), .manual_reset_req_n(mr_n),
		.power_fail_below_in(pf), .watchdog_kick_in(kick),
		.watchdog_kick_hiz(hiz), .reset_out_n(rst_n), .reset_out(rst_hi),
		.power_fail_flag_n(pf_n), .watchdog_expired_n(wdo_n));
	// Dual-polarity build on the same stimulus; it has no watchdog
	supervisor_reset_watchdog #(.VARIANT(2'h2), .RESET_CYCLES(RC), .WDOG_CYCLES(WC),
		.DEBOUNCE_CYCLES(4)) u_both (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.supply_low(supply_low), .manual_reset_req_n(mr_n),
		.power_fail_below_in(pf), .watchdog_kick_in(kick),
		.watchdog_kick_hiz(hiz), .reset_out_n(rst_n_b), .reset_out(rst_hi_b),
		.power_fail_flag_n(), .watchdog_expired_n(wdo_b));
	sup_kicker u_kick (.sys_clk(sys_clk), .alive(alive), .float_pin(hiz), .kick(kick));
	initial forever #2.5 sys_clk = ~sys_clk;
	task automatic cmp(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_len(input int got, input int lo, input int hi);
		cmp(got >= lo && got <= hi, 1'b1);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	// Bounded wait for the reset output to release
	task automatic stretch(output int c);
		c = 0;
		while (rst_n !== 1'b1 && c < 200)
		begin
			cyc(1);
			c++;
		end
	endtask
	task automatic final_report;
		$display("Checks %0d, errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard, far beyond the planned sequence
	initial
	begin
		cyc(4000);
		bad_count++;
		final_report;
	end
	// Main sequence, inputs change at falling edges
	initial
	begin
		n = $urandom(86);
		cyc(20);
		sys_rst = 1'b0;
		stretch(n);
		cmp_len(n, RC, RC + 4);
		repeat (16)
		begin
			pf = 1'($urandom);
			cyc(4);
			cmp(pf_n, !pf);
		end
		repeat (4)
		begin
			mr_n = 1'b0;
			cyc(2);
			mr_n = 1'b1;
			cyc(1);
		end
		cyc(8);
		cmp(rst_n, 1'b1);
		mr_n = 1'b0;
		cyc(12);
		cmp(rst_n, 1'b0);
		mr_n = 1'b1;
		stretch(n);
		cmp_len(n, RC, RC + 10);
		supply_low = 1'b1;
		cyc(8);
		cmp(rst_n, 1'b0);
		cmp(wdo_n, 1'b0);
		cmp(rst_hi_b, !rst_n_b);
		cmp(rst_hi_b, 1'b1);
		cmp(rst_hi, 1'b0);
		supply_low = 1'b0;
		cyc(4);
		cmp(wdo_n, 1'b1);
		stretch(n);
		cmp_len(n + 4, RC, RC + 6);
		cyc(3 * WC);
		cmp(wdo_n, 1'b1);
		alive = 1'b0;
		cyc(WC + 12);
		cmp(wdo_n, 1'b0);
		cmp(rst_n, 1'b1);
		cmp(wdo_b, 1'b1);
		cmp(rst_hi_b, !rst_n_b);
		cyc(WC);
		cmp(wdo_n, 1'b0);
		hiz = 1'b1;
		cyc(2 * WC);
		cmp(wdo_n, 1'b1);
		hiz = 1'b0;
		alive = 1'b1;
		cyc(WC);
		cmp(wdo_n, 1'b1);
		final_report;
	end
endmodule // supervisor_reset_watchdog_tb
`default_nettype wire
